// File: logic/cce_pkg.sv
package cce_pkg;
   // Channel and time-base counts
   localparam int unsigned CCE_NCHAN = 5;
   localparam int unsigned CCE_NTB = 3;
   localparam int unsigned CCE_NPWM = 2;

   // Register offsets on the byte-wide register port
   localparam logic [11:0] CCE_ADDR_TB_SEL = 12'h21f;
   localparam logic [11:0] CCE_ADDR_FLAGS = 12'h712;

   // Reset values
   localparam logic [7:0] CCE_TB_SEL_RST = 8'h00;
   localparam logic [4:0] CCE_FLAGS_RST = 5'h00;
   localparam logic [15:0] CCE_T1_RST = 16'h0000;
   localparam logic [7:0] CCE_TB_RST = 8'h00;
   localparam logic [7:0] CCE_RDATA_RST = 8'h00;

   // Field layout of the time-base select register
   localparam int unsigned CCE_TB_FIELD0_LSB = 2;
   localparam int unsigned CCE_TB_FIELD1_LSB = 4;
   localparam logic [7:0] CCE_TB_SEL_MASK = 8'h3c;

   // Time-base select codes
   localparam logic [1:0] CCE_TB_RSVD = 2'h0;
   localparam logic [1:0] CCE_TB_SECOND = 2'h1;
   localparam logic [1:0] CCE_TB_FOURTH = 2'h2;
   localparam logic [1:0] CCE_TB_SIXTH = 2'h3;

   // Channel mode codes
   localparam logic [1:0] CCE_MODE_OFF = 2'h0;
   localparam logic [1:0] CCE_MODE_CAPTURE = 2'h1;
   localparam logic [1:0] CCE_MODE_COMPARE = 2'h2;
   localparam logic [1:0] CCE_MODE_PWM = 2'h3;

   // Bit positions in the module disable bits
   localparam int unsigned CCE_MD_FIRST = 0;
   localparam int unsigned CCE_MD_SECOND = 1;
   localparam int unsigned CCE_MD_FOURTH = 2;
   localparam int unsigned CCE_MD_SIXTH = 3;
endpackage

// File: logic/cce_link_if.sv
`timescale 1ns/10ps
// Link between the channel glue and the companion timers
interface cce_link_if;
   logic [15:0] t1_count;
   logic [2:0][7:0] tb_count;
   logic special_trigger;

   modport chan_end (
      input t1_count,
      input tb_count,
      output special_trigger
   );

   modport timer_end (
      output t1_count,
      output tb_count,
      input special_trigger
   );
endinterface

// File: logic/cce_chan_end.sv
// How it works
// - Trigger clears first timer count to zero
// - Trigger clear never raises timer flag
// - Trigger channel still sets its own flag
// - Compare value acts as first timer period
// - Software count write beats trigger clear
// - Software keeps first timer synchronous, instruction-clocked
// - Asynchronous first timer may miss triggers
// - Disable bit holds timer in reset
// - Five flags in bits 4:0, reset zero
// - Capture sets flag until software clears
// - Compare match sets flag, software clears
// - PWM trailing edge sets channel flag
// - Select field picks second, fourth, sixth timer
// - Period match clears time-base next clock
`timescale 1ns/10ps
module cce_chan_end import cce_pkg::*; (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   cce_link_if.chan_end link, // Timer link
   input wire logic [11:0] reg_addr, // Register address
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_wdata, // Register write data
   output logic [7:0] reg_rdata, // Register read data
   input wire logic [4:0][1:0] chan_mode, // Mode per channel
   input wire logic [4:0] chan_trig_en, // Special trigger enable
   input wire logic [4:0][15:0] compare_value, // Compare or duty
   input wire logic [4:0] capture_in, // Capture inputs
   input wire logic [1:0][7:0] pwm_duty, // Duty of PWM outputs
   output logic [4:0] chan_out, // Channel outputs
   output logic [1:0] pwm_out, // PWM outputs
   output logic [4:0][15:0] capture_value, // Captured counts
   output logic [4:0] event_flags // Channel event flags
);

   // All state of the channel glue
   typedef struct packed {
      logic [7:0] tb_sel;
      logic [4:0] flags;
      logic [7:0] rdata;
      logic [4:0] cap_in;
      logic [4:0] match;
      logic [4:0] chan_out;
      logic [1:0] pwm_out;
      logic [4:0][15:0] cap_val;
   } cce_chan_st_t;

   cce_chan_st_t st_q;
   cce_chan_st_t st_d;
   logic [4:0] match_c;
   logic [4:0] set_c;
   logic trig_c;
   logic [1:0] tb_ok_c;
   logic [1:0][7:0] tb_cnt_c;

   // one time-base pick for each select field
   for (genvar g = 0; g < CCE_NPWM; g++) begin : gen_field
      // Bit position of this field
      localparam int unsigned FLSB = (g == 0) ? CCE_TB_FIELD0_LSB
         : CCE_TB_FIELD1_LSB;
      cce_tb_mux #(
         .CW(8)
      ) cce_tb_mux_i (
         .sel(st_q.tb_sel[FLSB +: 2]),
         .cnt(link.tb_count),
         .ok(tb_ok_c[g]),
         .val(tb_cnt_c[g])
      );
   end

   // Next-state logic
   always_comb begin
      st_d = st_q;
      set_c = 5'h00;
      trig_c = 1'b0;
      match_c = 5'h00;

      // Stand-alone PWM outputs, low while the select is reserved
      for (int p = 0; p < CCE_NPWM; p++) begin
         st_d.pwm_out[p] = tb_ok_c[p] && (tb_cnt_c[p] < pwm_duty[p]);
      end

      // Per-channel behaviour by mode
      for (int i = 0; i < CCE_NCHAN; i++) begin
         match_c[i] = (link.t1_count == compare_value[i]);
         st_d.cap_in[i] = capture_in[i];
         case (chan_mode[i])
            CCE_MODE_CAPTURE: begin
               st_d.chan_out[i] = 1'b0;
               // Rising edge of the synchronous capture input
               // capture event
               if (capture_in[i] && !st_q.cap_in[i]) begin
                  st_d.cap_val[i] = link.t1_count;
                  set_c[i] = 1'b1;
               end
            end
            CCE_MODE_COMPARE: begin
               st_d.chan_out[i] = match_c[i];
               if (match_c[i] && !st_q.match[i]) begin
                  set_c[i] = 1'b1;
               end
               // Level trigger, the timer clears on the next edge
               // compare is period
               if (match_c[i] && chan_trig_en[i]) begin
                  trig_c = 1'b1;
               end
            end
            CCE_MODE_PWM: begin
               // Channels in PWM mode run on the first select field
               st_d.chan_out[i] = tb_ok_c[0]
                  && (tb_cnt_c[0] < compare_value[i][7:0]);
               // Entering PWM from a high output also counts
               // trailing edge
               if (st_q.chan_out[i] && !st_d.chan_out[i]) begin
                  set_c[i] = 1'b1;
               end
            end
            default: begin
               st_d.chan_out[i] = 1'b0;
            end
         endcase
      end
      // Remember match levels for edge detection
      st_d.match = match_c;

      // set wins over a flag write
      if (reg_wr && (reg_addr == CCE_ADDR_FLAGS)) begin
         st_d.flags = reg_wdata[4:0] | set_c;
      end else begin
         st_d.flags = st_q.flags | set_c;
      end

      // Time-base select write, unimplemented bits stay zero
      if (reg_wr && (reg_addr == CCE_ADDR_TB_SEL)) begin
         st_d.tb_sel = reg_wdata & CCE_TB_SEL_MASK;
      end

      // Registered read, unmapped addresses read zero
      if (reg_rd) begin
         case (reg_addr)
            CCE_ADDR_FLAGS: st_d.rdata = {3'h0, st_q.flags};
            CCE_ADDR_TB_SEL: st_d.rdata = st_q.tb_sel;
            default: st_d.rdata = 8'h00;
         endcase
      end
   end

   // State register
   // Everything idles at zero after reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q.tb_sel <= CCE_TB_SEL_RST;
         st_q.flags <= CCE_FLAGS_RST;
         st_q.rdata <= CCE_RDATA_RST;
         st_q.cap_in <= 5'h00;
         st_q.match <= 5'h00;
         st_q.chan_out <= 5'h00;
         st_q.pwm_out <= 2'h0;
         st_q.cap_val <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs
   // Data outputs come straight from flip-flops
   assign reg_rdata = st_q.rdata;
   assign chan_out = st_q.chan_out;
   assign pwm_out = st_q.pwm_out;
   assign capture_value = st_q.cap_val;
   assign event_flags = st_q.flags;
   // Kept combinational so the timer acts in the match cycle
   // trigger request
   assign link.special_trigger = trig_c;

endmodule // cce_chan_end

// Picks one time-base count for a select field
module cce_tb_mux import cce_pkg::*; #(
   parameter int unsigned CW = 8 // Count width
) (
   input wire logic [1:0] sel, // Select field
   input wire logic [2:0][CW-1:0] cnt, // Counts of the time bases
   output logic ok, // A time base is selected
   output logic [CW-1:0] val // Selected count
);

   always_comb begin
      ok = 1'b1;
      val = cnt[0];
      case (sel)
         CCE_TB_SECOND: val = cnt[0];
         CCE_TB_FOURTH: val = cnt[1];
         CCE_TB_SIXTH: val = cnt[2];
         // Reserved code: nothing selected, output held low
         default: begin
            ok = 1'b0;
            val = '0;
         end
      endcase
   end

endmodule // cce_tb_mux

// File: logic/cce_timer_end.sv
`timescale 1ns/10ps
module cce_timer_end import cce_pkg::*; (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   cce_link_if.timer_end link, // Channel link
   input wire logic t1_on, // First timer runs
   input wire logic t1_sync, // First timer synchronous, clk-driven
   input wire logic t1_wr_high, // Write high count byte
   input wire logic t1_wr_low, // Write low count byte
   input wire logic [7:0] t1_wdata, // Count write data
   input wire logic t1_flag_clr, // Clear overflow flag
   output logic t1_flag, // First timer overflow flag
   input wire logic [2:0] tb_on, // Time-bases run
   input wire logic [2:0][7:0] tb_period, // Time-base periods
   input wire logic [3:0] module_disable, // Module disable bits
   output logic [2:0] tb_match // Period match pulses
);

   // All state of the companion timers
   typedef struct packed {
      logic [15:0] t1;
      logic t1_flag;
      logic [2:0][7:0] tb;
      logic [2:0] tb_match;
   } cce_tmr_st_t;

   cce_tmr_st_t st_q;
   cce_tmr_st_t st_d;

   // Next-state logic
   always_comb begin
      st_d = st_q;

      if (module_disable[CCE_MD_FIRST]) begin
         st_d.t1 = CCE_T1_RST;
         st_d.t1_flag = 1'b0;
      end else begin
         st_d.t1_flag = st_q.t1_flag & ~t1_flag_clr;
         if (t1_wr_high || t1_wr_low) begin
            if (t1_wr_high) begin
               st_d.t1[15:8] = t1_wdata;
            end
            if (t1_wr_low) begin
               st_d.t1[7:0] = t1_wdata;
            end
         end else if (link.special_trigger && t1_sync) begin
            st_d.t1 = CCE_T1_RST;
         end else if (t1_on) begin
            st_d.t1 = st_q.t1 + 16'h0001;
            if (st_q.t1 == 16'hffff) begin
               st_d.t1_flag = 1'b1;
            end
         end
      end

      for (int j = 0; j < CCE_NTB; j++) begin
         st_d.tb_match[j] = 1'b0;
         if (module_disable[CCE_MD_SECOND + j]) begin
            st_d.tb[j] = CCE_TB_RST;
         end else if (tb_on[j]) begin
            if (st_q.tb[j] == tb_period[j]) begin
               st_d.tb[j] = CCE_TB_RST;
               st_d.tb_match[j] = 1'b1;
            end else begin
               st_d.tb[j] = st_q.tb[j] + 8'h01;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q.t1 <= CCE_T1_RST;
         st_q.t1_flag <= 1'b0;
         st_q.tb <= '0;
         st_q.tb_match <= 3'h0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs
   assign link.t1_count = st_q.t1;
   assign link.tb_count = st_q.tb;
   assign t1_flag = st_q.t1_flag;
   assign tb_match = st_q.tb_match;

endmodule // cce_timer_end

// File: sim/cce_assertions.sv
`timescale 1ns/10ps
// Watches the timer link and the timer end
module cce_assertions (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [15:0] t1_count, // First count
   input wire logic [2:0][7:0] tb_count, // Base counts
   input wire logic special_trigger, // Trigger
   input wire logic t1_sync, // Sync mode
   input wire logic t1_on, // Timer runs
   input wire logic t1_wr_low, // Low write
   input wire logic t1_wr_high, // High write
   input wire logic [7:0] t1_wdata, // Write data
   input wire logic t1_flag, // Overflow flag
   input wire logic [2:0] tb_on, // Bases run
   input wire logic [2:0][7:0] tb_period, // Periods
   input wire logic [3:0] module_disable, // Disables
   input wire logic [2:0] tb_match // Matches
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Trigger that the timer must take
   wire wr = t1_wr_low | t1_wr_high;
   wire go = special_trigger & t1_sync & ~wr & ~module_disable[0];
   AST_TRIG_CLEAR: assert property (go |=> t1_count == 16'h0000)
      else $error("trigger left count");
   AST_TRIG_NO_FLAG: assert property (go && !t1_flag &&
      t1_count != 16'hffff |=> !t1_flag) else $error("trigger set flag");
   AST_WR_WINS: assert property (special_trigger && t1_wr_low &&
      !t1_wr_high && !module_disable[0] |=> t1_count[7:0] == $past(t1_wdata))
      else $error("write lost to trigger");
   AST_T1_STEP: assert property (t1_on && t1_sync && !special_trigger &&
      !wr && !module_disable[0] |=> t1_count == $past(t1_count) + 16'h0001)
      else $error("count restarted off match");
   AST_ASYNC_SKIP: assert property (special_trigger && !t1_sync && t1_on &&
      !wr && !module_disable[0] |=> t1_count == $past(t1_count) + 16'h0001)
      else $error("async timer took trigger");
   AST_T1_HELD: assert property (module_disable[0] |=>
      t1_count == 16'h0000 && !t1_flag) else $error("first timer not held");
   AST_TB_HELD: assert property (module_disable[1] |=>
      tb_count[0] == 8'h00) else $error("time base not held");
   AST_TB_WRAP: assert property (tb_on[0] && !module_disable[1] &&
      tb_count[0] == tb_period[0] |=> tb_count[0] == 8'h00 && tb_match[0])
      else $error("time base missed wrap");
   AST_TB_MATCH: assert property (tb_match[2] |-> tb_count[2] == 8'h00 &&
      $past(tb_count[2]) == $past(tb_period[2])) else $error("stray match");
   // Main scenarios reached
   cover property (go);
   cover property (special_trigger && t1_wr_low);
   cover property (tb_match[2]);
   cover property (special_trigger && !t1_sync);
   cover property (t1_flag);
endmodule // cce_assertions

// File: sim/tb.sv
`timescale 1ns/10ps
// Self-checking bench joining both ends
module tb;
   import cce_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, rv, t1_wdata = 8'h00;
   logic [4:0][1:0] chan_mode = 10'h000;
   logic [4:0] chan_trig_en = 5'h00;
   logic [4:0][15:0] compare_value = 80'h0;
   logic [4:0] capture_in = 5'h00;
   logic [1:0][7:0] pwm_duty = 16'h0000;
   logic [4:0] chan_out, event_flags;
   logic [1:0] pwm_out;
   logic [4:0][15:0] capture_value;
   logic t1_on = 1'b0, t1_sync = 1'b1, t1_wr_high = 1'b0, t1_wr_low = 1'b0;
   logic t1_flag_clr = 1'b0, t1_flag;
   logic [1:0] exp_pwm;
   logic [2:0] tb_on = 3'h0, tb_match;
   logic [2:0][7:0] tb_period = 24'h070503;
   logic [3:0] module_disable = 4'h0;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   cce_link_if link();
   cce_chan_end cce_chan_end_i (.clk(clk), .sys_rst(sys_rst),
      .link(link.chan_end), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .chan_mode(chan_mode), .chan_trig_en(chan_trig_en),
      .compare_value(compare_value), .capture_in(capture_in),
      .pwm_duty(pwm_duty), .chan_out(chan_out), .pwm_out(pwm_out),
      .capture_value(capture_value), .event_flags(event_flags));
   cce_timer_end cce_timer_end_i (.clk(clk), .sys_rst(sys_rst),
      .link(link.timer_end), .t1_on(t1_on), .t1_sync(t1_sync),
      .t1_wr_high(t1_wr_high), .t1_wr_low(t1_wr_low), .t1_wdata(t1_wdata),
      .t1_flag_clr(t1_flag_clr), .t1_flag(t1_flag), .tb_on(tb_on),
      .tb_period(tb_period), .module_disable(module_disable),
      .tb_match(tb_match));
   cce_assertions cce_assertions_i (.clk(clk), .sys_rst(sys_rst),
      .t1_count(link.t1_count), .tb_count(link.tb_count),
      .special_trigger(link.special_trigger), .t1_sync(t1_sync),
      .t1_on(t1_on), .t1_wr_low(t1_wr_low), .t1_wr_high(t1_wr_high),
      .t1_wdata(t1_wdata), .t1_flag(t1_flag), .tb_on(tb_on),
      .tb_period(tb_period), .module_disable(module_disable),
      .tb_match(tb_match));
   // Clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   // Compare and count
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // Wait whole cycles, then step off the edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Register port write and read
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [11:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      rv = reg_rdata;
      cyc(1);
   endtask
   // Count cycles until the trigger is high
   task automatic wait_trig;
      n = 0;
      while (link.special_trigger !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic finish_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      cyc(3);
      sys_rst = 1'b0;
      rd(CCE_ADDR_FLAGS);
      chk("flags reset", 16'(rv), 16'h0000);
      wr(CCE_ADDR_TB_SEL, 8'hff);
      rd(CCE_ADDR_TB_SEL);
      chk("select mask", 16'(rv), 16'h003c);
      rd(12'h123);
      chk("unmapped read", 16'(rv), 16'h0000);
      chan_mode[0] = CCE_MODE_COMPARE;
      chan_trig_en[0] = 1'b1;
      compare_value[0] = 16'h0009;
      t1_on = 1'b1;
      tb_on = 3'h7;
      wait_trig();
      cyc(1);
      chk("count cleared", link.t1_count, 16'h0000);
      chk("chan flag", 16'(event_flags[0]), 16'h0001);
      chk("timer flag", 16'(t1_flag), 16'h0000);
      chk("compare out", 16'(chan_out[0]), 16'h0001);
      wait_trig();
      chk("period", 16'(n), 16'h0009);
      wr(CCE_ADDR_FLAGS, 8'h00);
      chk("set beats clear", 16'(event_flags[0]), 16'h0001);
      wr(CCE_ADDR_FLAGS, 8'h00);
      chk("flag cleared", 16'(event_flags[0]), 16'h0000);
      wait_trig();
      t1_wdata = 8'h05;
      t1_wr_low = 1'b1;
      cyc(1);
      t1_wr_low = 1'b0;
      chk("write wins", link.t1_count, 16'h0005);
      chan_mode[2] = CCE_MODE_CAPTURE;
      capture_in[2] = 1'b1;
      cyc(2);
      capture_in[2] = 1'b0;
      chk("capture flag", 16'(event_flags[2]), 16'h0001);
      chk("capture value", capture_value[2], 16'h0005);
      wr(CCE_ADDR_FLAGS, 8'h00);
      chk("capture clear", 16'(event_flags[2]), 16'h0000);
      pwm_duty[0] = 8'h02;
      pwm_duty[1] = 8'h04;
      for (int s = 0; s < 4; s++) begin
         wr(CCE_ADDR_TB_SEL, 8'((s << 2) | (s << 4)));
         for (int k = 0; k < 9; k++) begin
            exp_pwm[0] = (s == 0) ? 1'b0 : (link.tb_count[s - 1] < 8'h02);
            exp_pwm[1] = (s == 0) ? 1'b0 : (link.tb_count[s - 1] < 8'h04);
            cyc(1);
            chk("pwm source", 16'(pwm_out[0]), 16'(exp_pwm[0]));
            chk("pwm field two", 16'(pwm_out[1]), 16'(exp_pwm[1]));
         end
      end
      chan_mode[1] = CCE_MODE_PWM;
      compare_value[1] = 16'h0002;
      cyc(20);
      chk("pwm flag", 16'(event_flags[1]), 16'h0001);
      // asynchronous timer lets the trigger pass
      t1_sync = 1'b0;
      wait_trig();
      cyc(1);
      chk("async keeps count", link.t1_count, 16'h000a);
      t1_sync = 1'b1;
      t1_wdata = 8'hff;
      t1_wr_high = 1'b1;
      t1_wr_low = 1'b1;
      cyc(1);
      t1_wr_high = 1'b0;
      t1_wr_low = 1'b0;
      t1_flag_clr = 1'b1;
      chk("both bytes", link.t1_count, 16'hffff);
      cyc(1);
      chk("overflow beats clear", 16'(t1_flag), 16'h0001);
      cyc(1);
      t1_flag_clr = 1'b0;
      chk("overflow cleared", 16'(t1_flag), 16'h0000);
      module_disable = 4'hf;
      cyc(2);
      chk("timer held", link.t1_count, 16'h0000);
      chk("base held", 16'(link.tb_count[2]), 16'h0000);
      module_disable = 4'h0;
      rd(CCE_ADDR_FLAGS);
      chk("upper bits", 16'(rv[7:5]), 16'h0000);
      finish_test();
   end
endmodule // tb
